// File: eqlp_pkg.sv
package eqlp_pkg;

   // ****************************************************************
   // register map (byte addresses, one aligned word each)
   // ****************************************************************
   localparam logic [7:0] ADDR_CTRL = 8'h00; // usb enable, save mode, clear
   localparam logic [7:0] ADDR_ERR_PUSH = 8'h04; // write: log an error code
   localparam logic [7:0] ADDR_ERR_POP = 8'h08; // read: oldest error
   localparam logic [7:0] ADDR_Q_STAT = 8'h0C; // count, empty, full, led
   localparam logic [7:0] ADDR_LIMIT = 8'h10; // write: reading limit result
   localparam logic [7:0] ADDR_REV = 8'h14; // firmware revisions
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h18; // sticky events, w1c
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h1C; // event mask

   // ****************************************************************
   // control fields
   // ****************************************************************
   localparam int CTRL_USB_EN = 0; // 1: usb active, pulses off
   localparam int CTRL_SAVE = 1; // 1: keep config over restart
   localparam int CTRL_CLS = 2; // write 1: clear queue
   localparam logic [31:0] CTRL_RESET = 32'h0000_0001;

   // limit word fields: bit0 valid, bit1 fail(1)/pass(0)
   localparam int LIM_VALID = 0;
   localparam int LIM_FAIL = 1;

   // status fields
   localparam int QS_EMPTY = 8;
   localparam int QS_FULL = 9;
   localparam int QS_LED = 10;

   // event bits
   localparam int EV_ERR = 0; // error logged
   localparam int EV_OVF = 1; // overflow marker written
   localparam int EV_PULSE = 2; // pass/fail pulse ended
   localparam int EV_W = 3;

   // ****************************************************************
   // queue and codes
   // ****************************************************************
   localparam int Q_DEPTH = 20;
   localparam int Q_AW = 5;
   localparam int CODE_W = 16;
   localparam logic signed [CODE_W-1:0] CODE_OVF = -16'sd350;
   localparam logic signed [CODE_W-1:0] CODE_NONE = 16'sh0000; // no errors

   // revisions, values arbitrary
   localparam logic [7:0] REV_MEAS = 8'h01;
   localparam logic [7:0] REV_IO = 8'h02;
   localparam logic [7:0] REV_PANEL = 8'h03;

   // ****************************************************************
   // timing
   // ****************************************************************
   localparam int CLK_MHZ = 100;
   localparam int PULSE_US = 2000; // nominal active-low time
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int PCNT_W = 18;

endpackage

// File: eqlp_fifo.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// error queue: fixed depth, overflow marks newest slot
// ****************************************************************
module eqlp_fifo (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // control
   input wire logic push,
   input wire logic signed [eqlp_pkg::CODE_W-1:0] push_code,
   input wire logic pop,
   input wire logic clr,
   // state
   output logic signed [eqlp_pkg::CODE_W-1:0] head,
   output logic [eqlp_pkg::Q_AW:0] count,
   output logic empty,
   output logic full,
   output logic ovf_hit
);
   // storage array, one signed code a slot
   logic signed [eqlp_pkg::CODE_W-1:0] mem [eqlp_pkg::Q_DEPTH];
   logic [eqlp_pkg::Q_AW-1:0] rd_q;
   logic [eqlp_pkg::Q_AW-1:0] wr_q;
   logic [eqlp_pkg::Q_AW:0] cnt_q;

   // wrap a pointer at the queue depth
   function automatic logic [eqlp_pkg::Q_AW-1:0] nxt(
      input logic [eqlp_pkg::Q_AW-1:0] p);
      if (p == eqlp_pkg::Q_AW'(eqlp_pkg::Q_DEPTH - 1)) begin
         nxt = '0;
      end else begin
         nxt = p + 1'b1;
      end
   endfunction

   function automatic logic [eqlp_pkg::Q_AW-1:0] prv(
      input logic [eqlp_pkg::Q_AW-1:0] p);
      if (p == '0) begin
         prv = eqlp_pkg::Q_AW'(eqlp_pkg::Q_DEPTH - 1);
      end else begin
         prv = p - 1'b1;
      end
   endfunction

   assign empty = (cnt_q == '0);
   assign full = (cnt_q == (eqlp_pkg::Q_AW+1)'(eqlp_pkg::Q_DEPTH));
   assign count = cnt_q;
   assign head = mem[rd_q]; // oldest entry first
   assign ovf_hit = push & full & ~pop & ~clr;

   // pointers and count; clear wins, push on full overwrites newest
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
      end else if (clr) begin
         rd_q <= '0;
         wr_q <= '0;
         cnt_q <= '0;
      end else begin
         if (pop && !empty) begin
            rd_q <= nxt(rd_q);
         end
         if (push && (!full || pop)) begin
            wr_q <= nxt(wr_q);
         end
         if (push && !full && !(pop && !empty)) begin
            cnt_q <= cnt_q + 1'b1;
         end else if (!push && pop && !empty) begin
            cnt_q <= cnt_q - 1'b1;
         end
      end
   end

   // data slots; no reset needed, count guards reads
   always_ff @(posedge hclk) begin
      if (!clr && push) begin
         if (full && !pop) begin
            mem[prv(wr_q)] <= eqlp_pkg::CODE_OVF;
         end else begin
            mem[wr_q] <= push_code;
         end
      end
   end
endmodule
`default_nettype wire

// File: eqlp_pulse.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// pass/fail pulse timer, low-true outputs
// ****************************************************************
module eqlp_pulse #(
   // active-low time in clock cycles; default is the nominal 2 ms
   parameter int PULSE_CYC = eqlp_pkg::PULSE_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // request
   input wire logic start,
   input wire logic fail,
   // state
   output logic pass_n,
   output logic fail_n,
   output logic done
);
   logic [eqlp_pkg::PCNT_W-1:0] cnt_q;
   logic busy_q;
   logic fail_q;

   // count cycles; terminal count equals nominal length
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt_q <= '0;
         busy_q <= 1'b0;
         fail_q <= 1'b0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         if (start && !busy_q) begin
            busy_q <= 1'b1;
            fail_q <= fail;
            cnt_q <= eqlp_pkg::PCNT_W'(1);
         end else if (busy_q) begin
            if (cnt_q == eqlp_pkg::PCNT_W'(PULSE_CYC)) begin
               busy_q <= 1'b0;
               done <= 1'b1;
            end else begin
               cnt_q <= cnt_q + 1'b1;
            end
         end
      end
   end

   assign pass_n = ~(busy_q & ~fail_q);
   assign fail_n = ~(busy_q & fail_q);
endmodule
`default_nettype wire

// File: eqlp_top.sv
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - error light on while queue holds entries
// - errors returned oldest first
// - twenty entries; overflow writes code -350 newest
// - light goes off once queue read empty
// - empty read returns no-errors code
// - power-down or clear command empties queue
// - usb disabled: pass on d-, fail d+
// - low-true outputs report next reading result
// - pulse low about two milliseconds per reading
// - disabling usb enables pass/fail output
// - revision: measure, io, panel in order
// - power-up choice: saved or factory settings
module eqlp_top #(
   // pulse length in clock cycles; a bench may shorten it to save time
   parameter int PULSE_CYC = eqlp_pkg::PULSE_CYC
) (
   // clock and reset
   input wire logic hclk,
   input wire logic hresetn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // usb contacts, d- pass, d+ fail
   output logic usb_dm_o,
   output logic usb_dm_oe,
   output logic usb_dp_o,
   output logic usb_dp_oe,
   // front panel and system
   output logic err_led,
   output logic save_cfg,
   output logic irq
);
   // ****************************************************************
   // bus address phase capture
   // ****************************************************************
   logic ap_wr_q;
   logic ap_rd_q;
   logic [7:0] ap_addr_q;
   logic [31:0] ctrl_q;
   logic [eqlp_pkg::EV_W-1:0] ev_q;
   logic [eqlp_pkg::EV_W-1:0] mask_q;
   logic lim_valid_q;
   logic lim_fail_q;
   // fifo and pulse wiring
   logic q_push;
   logic q_pop;
   logic q_clr;
   logic signed [eqlp_pkg::CODE_W-1:0] q_head;
   logic [eqlp_pkg::Q_AW:0] q_count;
   logic q_empty;
   logic q_full;
   logic q_ovf;
   logic p_pass_n;
   logic p_fail_n;
   logic p_done;
   logic p_start;
   logic ap_take;

   assign ap_take = hsel & hready & htrans[1];

   // latch a valid address phase for the next data phase
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_wr_q <= 1'b0;
         ap_rd_q <= 1'b0;
         ap_addr_q <= '0;
      end else if (hready) begin
         ap_wr_q <= ap_take & hwrite;
         ap_rd_q <= ap_take & ~hwrite;
         ap_addr_q <= haddr[7:0];
      end
   end

   // zero wait state, always okay
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // ****************************************************************
   // write decode, plus pop on read
   // ****************************************************************
   function automatic logic hit(input logic [7:0] a, input logic [7:0] r);
      hit = (a == r);
   endfunction

   assign q_push = ap_wr_q & hit(ap_addr_q, eqlp_pkg::ADDR_ERR_PUSH);
   // pop on read of the error word; empty read pops nothing
   assign q_pop = ap_rd_q & hit(ap_addr_q, eqlp_pkg::ADDR_ERR_POP);
   assign q_clr = ap_wr_q & hit(ap_addr_q, eqlp_pkg::ADDR_CTRL)
                  & hwdata[eqlp_pkg::CTRL_CLS];

   // control register; reset (power-up) sets usb enabled
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= eqlp_pkg::CTRL_RESET;
      end else if (ap_wr_q && hit(ap_addr_q, eqlp_pkg::ADDR_CTRL)) begin
         ctrl_q <= 32'h0000_0000;
         ctrl_q[eqlp_pkg::CTRL_USB_EN] <= hwdata[eqlp_pkg::CTRL_USB_EN];
         ctrl_q[eqlp_pkg::CTRL_SAVE] <= hwdata[eqlp_pkg::CTRL_SAVE];
      end
   end

   // power-up choice is a level out to the config store
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         save_cfg <= 1'b0;
      end else begin
         save_cfg <= ctrl_q[eqlp_pkg::CTRL_SAVE];
      end
   end

   // pending limit result for the next reading sent out
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         lim_valid_q <= 1'b0;
         lim_fail_q <= 1'b0;
      end else if (ap_wr_q && hit(ap_addr_q, eqlp_pkg::ADDR_LIMIT)) begin
         lim_valid_q <= hwdata[eqlp_pkg::LIM_VALID];
         lim_fail_q <= hwdata[eqlp_pkg::LIM_FAIL];
      end else begin
         lim_valid_q <= 1'b0;
      end
   end
   // pulses only while usb is off; results while usb is on are dropped
   assign p_start = lim_valid_q & ~ctrl_q[eqlp_pkg::CTRL_USB_EN];

   // ****************************************************************
   // sub-blocks
   // ****************************************************************
   eqlp_fifo u_fifo (
      .hclk(hclk),
      .hresetn(hresetn),
      .push(q_push),
      .push_code(hwdata[eqlp_pkg::CODE_W-1:0]),
      .pop(q_pop),
      .clr(q_clr),
      .head(q_head),
      .count(q_count),
      .empty(q_empty),
      .full(q_full),
      .ovf_hit(q_ovf)
   );

   eqlp_pulse #(.PULSE_CYC(PULSE_CYC)) u_pulse (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(p_start),
      .fail(lim_fail_q),
      .pass_n(p_pass_n),
      .fail_n(p_fail_n),
      .done(p_done)
   );

   // ****************************************************************
   // pins: registered, driven only with usb disabled
   // ****************************************************************
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         usb_dm_o <= 1'b1;
         usb_dp_o <= 1'b1;
         usb_dm_oe <= 1'b0;
         usb_dp_oe <= 1'b0;
      end else begin
         usb_dm_o <= p_pass_n;
         usb_dp_o <= p_fail_n;
         usb_dm_oe <= ~ctrl_q[eqlp_pkg::CTRL_USB_EN];
         usb_dp_oe <= ~ctrl_q[eqlp_pkg::CTRL_USB_EN];
      end
   end

   // error light follows queue occupancy
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         err_led <= 1'b0;
      end else begin
         err_led <= ~q_empty;
      end
   end

   // ****************************************************************
   // interrupts: sticky, set beats w1c clear
   // ****************************************************************
   logic [eqlp_pkg::EV_W-1:0] ev_set;
   logic [eqlp_pkg::EV_W-1:0] ev_clr;
   assign ev_set = {p_done, q_ovf, q_push & ~q_clr};
   assign ev_clr = (ap_wr_q && hit(ap_addr_q, eqlp_pkg::ADDR_IRQ_STAT))
                   ? hwdata[eqlp_pkg::EV_W-1:0] : '0;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ev_q <= '0;
      end else begin
         ev_q <= (ev_q & ~ev_clr) | ev_set;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mask_q <= '0;
      end else if (ap_wr_q && hit(ap_addr_q, eqlp_pkg::ADDR_IRQ_MASK)) begin
         mask_q <= hwdata[eqlp_pkg::EV_W-1:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(((ev_q & ~ev_clr) | ev_set) & mask_q);
      end
   end

   // ****************************************************************
   // read mux, registered; data valid in data phase after next edge
   // ****************************************************************
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      unique case (haddr[7:0])
         eqlp_pkg::ADDR_CTRL: rd_d = ctrl_q;
         eqlp_pkg::ADDR_ERR_POP: begin
            if (!q_empty) begin
               rd_d = {{(32-eqlp_pkg::CODE_W){q_head[eqlp_pkg::CODE_W-1]}},
                       q_head};
            end else begin
               rd_d = 32'(eqlp_pkg::CODE_NONE);
            end
         end
         eqlp_pkg::ADDR_Q_STAT: begin
            rd_d[eqlp_pkg::Q_AW:0] = q_count;
            rd_d[eqlp_pkg::QS_EMPTY] = q_empty;
            rd_d[eqlp_pkg::QS_FULL] = q_full;
            rd_d[eqlp_pkg::QS_LED] = err_led;
         end
         eqlp_pkg::ADDR_REV: rd_d = {8'h00, eqlp_pkg::REV_MEAS,
                                   eqlp_pkg::REV_IO,
                                   eqlp_pkg::REV_PANEL};
         eqlp_pkg::ADDR_IRQ_STAT: rd_d[eqlp_pkg::EV_W-1:0] = ev_q;
         eqlp_pkg::ADDR_IRQ_MASK: rd_d[eqlp_pkg::EV_W-1:0] = mask_q;
         default: rd_d = 32'h0000_0000;
      endcase
   end

   // capture in the address phase; a back-to-back pop could see stale
   // head, so the master must leave one idle cycle between pops
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (ap_take && !hwrite) begin
         hrdata <= rd_d;
      end
   end

   // ****************************************************************
   // checks
   // ****************************************************************
   a_led_tracks_q: assert property (@(posedge hclk)
      disable iff (!hresetn) !q_empty |=> err_led)
      else $error("light off with errors held");
   a_led_off_empty: assert property (@(posedge hclk)
      disable iff (!hresetn) q_empty |=> !err_led)
      else $error("light on with empty queue");
   a_depth_limit: assert property (@(posedge hclk)
      disable iff (!hresetn)
      q_count <= (eqlp_pkg::Q_AW+1)'(eqlp_pkg::Q_DEPTH))
      else $error("queue past depth");
   a_cls_empties: assert property (@(posedge hclk)
      disable iff (!hresetn) q_clr |=> q_empty)
      else $error("clear left entries");
   a_no_pulse_usb: assert property (@(posedge hclk)
      disable iff (!hresetn)
      ctrl_q[eqlp_pkg::CTRL_USB_EN] |=> !usb_dm_oe && !usb_dp_oe)
      else $error("pins driven with usb on");
   a_pulse_len: assert property (@(posedge hclk)
      disable iff (!hresetn) $fell(p_pass_n) |-> !p_pass_n [*8])
      else $error("pass pulse short");
   a_one_line: assert property (@(posedge hclk)
      disable iff (!hresetn) !(!p_pass_n && !p_fail_n))
      else $error("both lines low");
   a_pin_follows: assert property (@(posedge hclk)
      disable iff (!hresetn) 1'b1 |=> usb_dp_o == $past(p_fail_n))
      else $error("fail pin lag");
endmodule
`default_nettype wire

// File: eqlp_fixture.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// test fixture: times the low-true pass/fail pulses
// ****************************************************************
module eqlp_fixture (
   // clock and power sense
   input wire logic hclk,
   input wire logic hresetn,
   // connector lines, pulled up on the fixture side
   input wire logic pass_line,
   input wire logic fail_line,
   // one report per finished pulse: {fail, cycles low}
   output logic rep_v,
   output logic [31:0] rep_word
);
   logic [30:0] len_q; // cycles seen low so far
   logic kind_q; // 1: the fail line was the low one
   logic busy_q; // a pulse is being timed

   initial begin
      rep_v = 1'b0;
      rep_word = 32'h0000_0000;
      len_q = '0;
      kind_q = 1'b0;
      busy_q = 1'b0;
   end

   // no usb cable is plugged, only the device drives the lines
   always @(posedge hclk) begin
      rep_v <= 1'b0;
      if (!hresetn) begin
         // a pulse cut by power loss is dropped, not reported
         busy_q <= 1'b0;
         len_q <= '0;
      end else if (!pass_line || !fail_line) begin
         busy_q <= 1'b1;
         kind_q <= !fail_line;
         len_q <= len_q + 31'd1;
      end else if (busy_q) begin
         rep_v <= 1'b1;
         rep_word <= {kind_q, len_q};
         busy_q <= 1'b0;
         len_q <= '0;
      end
   end
endmodule
`default_nettype wire

// File: tb_eqlp_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_eqlp_top;
   // ****************************************************************
   // signals
   // ****************************************************************
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'b00;
   logic hwrite = 1'b0;
   logic [2:0] hsize = 3'b010; // whole words only
   logic [31:0] hwdata = 32'h0000_0000;
   logic [31:0] hrdata;
   logic hreadyout, hresp, err_led, save_cfg, irq;
   logic usb_dm_o, usb_dm_oe, usb_dp_o, usb_dp_oe;
   logic dm_lvl, dp_lvl, rep_v;
   logic [31:0] rep_word;
   logic rd_dp = 1'b0; // a read data phase is in progress
   logic [31:0] exp_q[$]; // expected read data, oldest first
   logic [31:0] pexp_q[$]; // expected pulse reports
   logic [15:0] codes[$]; // codes pushed, oldest first
   logic [15:0] seed = 16'hAF71;
   logic [15:0] c;
   int fails = 0;
   int n_tests = 0;
   int n;
   localparam int P_CYC = 2000; // short pulse keeps the run brief

   always #5 hclk = ~hclk;
   // fixture pull-ups win whenever the device lets go of a line
   assign dm_lvl = usb_dm_oe ? usb_dm_o : 1'b1;
   assign dp_lvl = usb_dp_oe ? usb_dp_o : 1'b1;

   eqlp_top #(.PULSE_CYC(P_CYC)) i_eqlp_top (.hclk(hclk),
      .hresetn(hresetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .usb_dm_o(usb_dm_o),
      .usb_dm_oe(usb_dm_oe), .usb_dp_o(usb_dp_o), .usb_dp_oe(usb_dp_oe),
      .err_led(err_led), .save_cfg(save_cfg), .irq(irq));
   eqlp_fixture i_eqlp_fixture (.hclk(hclk), .hresetn(hresetn),
      .pass_line(dm_lvl), .fail_line(dp_lvl), .rep_v(rep_v),
      .rep_word(rep_word));

   // ****************************************************************
   // helpers
   // ****************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask

   task automatic results;
      $display("checks %0d, mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // wait for hready sampled high, bounded
   task automatic wait_rdy;
      int k;
      k = 0;
      do begin
         @(posedge hclk);
         k++;
      end while (hreadyout !== 1'b1 && k < 50);
      if (hreadyout !== 1'b1) begin
         fails++;
         results();
      end
   endtask

   // one single transfer; leading edge leaves an idle cycle between
   task automatic xfer(input logic [7:0] a, input logic w,
                       input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h00_0000, a};
      hwrite <= w;
      htrans <= 2'b10;
      wait_rdy();
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      rd_dp <= !w;
      wait_rdy();
      rd_dp <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(a, 1'b0, 32'h0000_0000);
   endtask

   // let registered outputs land before looking at them
   task automatic settle;
      repeat (3) @(posedge hclk);
      #1;
   endtask

   // ****************************************************************
   // monitor: each result takes the oldest note off its queue
   // ****************************************************************
   always @(posedge hclk) begin
      if (rd_dp && hreadyout === 1'b1) begin
         check({31'h0, hresp}, 32'h0000_0000);
         if (exp_q.size() == 0) begin
            check(hrdata, 32'hxxxx_xxxx);
         end else begin
            check(hrdata, exp_q.pop_front());
         end
      end
      if (rep_v === 1'b1) begin
         if (pexp_q.size() == 0) begin
            check(rep_word, 32'hxxxx_xxxx); // pulse that was not asked for
         end else begin
            check(rep_word, pexp_q.pop_front());
         end
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      repeat (10) @(posedge hclk);
      hresetn <= 1'b1;
      rd(eqlp_pkg::ADDR_CTRL, eqlp_pkg::CTRL_RESET);
      rd(eqlp_pkg::ADDR_Q_STAT, 32'h0000_0100);
      rd(eqlp_pkg::ADDR_REV, {8'h00, eqlp_pkg::REV_MEAS, eqlp_pkg::REV_IO,
         eqlp_pkg::REV_PANEL});
      wr(8'h40, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0000_0000);
      rd(eqlp_pkg::ADDR_ERR_POP, 32'h0000_0000);
      settle();
      check({31'h0, err_led}, 32'h0000_0000);
      check({usb_dm_oe, usb_dp_oe}, 32'h0000_0000);
      // fill past depth with random codes
      for (int i = 0; i < 21; i++) begin
         seed = lfsr(seed);
         codes.push_back(seed);
         wr(eqlp_pkg::ADDR_ERR_PUSH, {16'h0000, seed});
      end
      settle();
      check({31'h0, err_led}, 32'h0000_0001);
      rd(eqlp_pkg::ADDR_Q_STAT, 32'h0000_0614);
      for (int i = 0; i < 19; i++) begin
         c = codes.pop_front();
         rd(eqlp_pkg::ADDR_ERR_POP, {{16{c[15]}}, c});
      end
      rd(eqlp_pkg::ADDR_ERR_POP, 32'hFFFF_FEA2);
      rd(eqlp_pkg::ADDR_ERR_POP, 32'h0000_0000);
      settle();
      check({31'h0, err_led}, 32'h0000_0000);
      // interrupt: masked, unmasked, cleared
      wr(eqlp_pkg::ADDR_IRQ_MASK, 32'h0000_0000);
      settle();
      check({31'h0, irq}, 32'h0000_0000);
      wr(eqlp_pkg::ADDR_IRQ_MASK, 32'h0000_0003);
      settle();
      check({31'h0, irq}, 32'h0000_0001);
      rd(eqlp_pkg::ADDR_IRQ_STAT, 32'h0000_0003);
      wr(eqlp_pkg::ADDR_IRQ_STAT, 32'h0000_0007);
      settle();
      check({31'h0, irq}, 32'h0000_0000);
      rd(eqlp_pkg::ADDR_IRQ_STAT, 32'h0000_0000);
      // clear command, then save choice and a power cycle
      wr(eqlp_pkg::ADDR_ERR_PUSH, 32'h0000_0123);
      wr(eqlp_pkg::ADDR_CTRL, 32'h0000_0005);
      rd(eqlp_pkg::ADDR_Q_STAT, 32'h0000_0100);
      rd(eqlp_pkg::ADDR_CTRL, 32'h0000_0001);
      wr(eqlp_pkg::ADDR_CTRL, 32'h0000_0003);
      wr(eqlp_pkg::ADDR_ERR_PUSH, 32'h0000_0456);
      settle();
      check({31'h0, save_cfg}, 32'h0000_0001);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (2) @(posedge hclk);
      hresetn <= 1'b1;
      rd(eqlp_pkg::ADDR_Q_STAT, 32'h0000_0100);
      // result while usb is active goes nowhere
      wr(eqlp_pkg::ADDR_LIMIT, 32'h0000_0003);
      wr(eqlp_pkg::ADDR_CTRL, 32'h0000_0000);
      settle();
      check({save_cfg, usb_dm_oe, usb_dp_oe, dm_lvl, dp_lvl},
         32'h0000_000F);
      // fail pulse; a second result while busy is dropped
      pexp_q.push_back({1'b1, 31'(P_CYC)});
      wr(eqlp_pkg::ADDR_LIMIT, 32'h0000_0003);
      wr(eqlp_pkg::ADDR_LIMIT, 32'h0000_0001);
      n = 0;
      while (pexp_q.size() != 0 && n < P_CYC + 100) begin
         @(posedge hclk);
         n++;
      end
      check(pexp_q.size(), 32'h0000_0000);
      if (pexp_q.size() != 0) begin
         results();
      end
      settle();
      rd(eqlp_pkg::ADDR_IRQ_STAT, 32'h0000_0004);
      // pass pulse start, then power is cut mid-pulse
      wr(eqlp_pkg::ADDR_LIMIT, 32'h0000_0001);
      n = 0;
      while (dm_lvl !== 1'b0 && n < 20) begin
         @(posedge hclk);
         n++;
      end
      check({dm_lvl, dp_lvl}, 32'h0000_0001);
      if (dm_lvl !== 1'b0) begin
         results();
      end
      @(posedge hclk);
      hresetn <= 1'b0;
      settle();
      check({usb_dm_oe, usb_dp_oe}, 32'h0000_0000);
      @(posedge hclk);
      hresetn <= 1'b1;
      repeat (5) @(posedge hclk);
      check(exp_q.size() + pexp_q.size(), 32'h0000_0000);
      results();
   end
endmodule
`default_nettype wire
